//--- verilog/msmb_pkg.sv
// msmb_pkg: constants and types shared by the monitor serial port ends.
// assumes a 50 MHz mclk on both ends and open-drain lines resolved in msmb_if.
package msmb_pkg;
	localparam int MCLK_NS       = 20;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYC   = SCL_PERIOD_NS / (4 * MCLK_NS);

	// three-level strap codes
	localparam logic [1:0] PIN_LOW  = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_OPEN = 2'h2;

	localparam logic [1:0] ADDR_TOP  = 2'h2;
	localparam logic [6:0] MASS_ADDR = 7'h5f;
	localparam logic [6:0] ARA_ADDR  = 7'h0c;

	localparam logic [2:0] PTR_CTRL   = 3'h0;
	localparam logic [2:0] PTR_RESET  = 3'h0;
	localparam int         MWE_BIT    = 4;
	localparam logic [7:0] CTRL_RESET = 8'h10;

	localparam logic [2:0] STEP_ABORT = 3'h7;

	typedef enum logic [1:0] {KIND_WRITE, KIND_READ, KIND_ARA} msmb_kind_t;
	typedef enum logic [2:0] {OP_START, OP_TX, OP_RX, OP_STOP} msmb_op_t;
endpackage : msmb_pkg

//--- verilog/msmb_if.sv
// msmb_if: the two-wire bus plus alert line between host and device.
// assumes both ends only ever pull low; released lines read high.
`timescale 1ns/1ns
interface msmb_if;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic dev_alert_o;
	logic dev_alert_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic scl;
	logic sda;
	logic alert_n;

	assign scl     = host_scl_oe ? host_scl_o : 1'b1;
	assign sda     = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);
	assign alert_n = dev_alert_oe ? dev_alert_o : 1'b1;

	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
		output dev_alert_o, output dev_alert_oe);
	modport host (input scl, input sda, input alert_n, output host_scl_o,
		output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface : msmb_if

//--- verilog/msmb_sync.sv
// msmb_sync: two-flop synchroniser for levels from outside the mclk domain.
// assumes inputs are quasi-static or slow against mclk; resets to released-high.
`timescale 1ns/1ns
module msmb_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_q <= '1;
			dout   <= '1;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : msmb_sync

//--- verilog/msmb_slave.sv
// msmb_slave: device end of the monitor serial port, a byte/word read-write slave.
// assumes host keeps scl low long enough (>= 3 mclk) for sampling, no clock stretch.
// How it works
// - slave for byte and word reads/writes
// - host leaves both lines high when idle
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - three three-level straps pick 27 addresses
// - top two address bits fixed to 10
// - straps high, open, high give 1010011
// - broadcast write address 1011111 also accepted
// - broadcast ignored when mass-write enable is zero
// - alert-response read returns own address, frees alert
// - transmitter releases sda in ack slot
// - receiver holds sda low whole ack pulse
// - host may stop after a missing ack
// - host acks bytes, nacks last, then stops
// - command byte low three bits load pointer
// - write data byte stored at pointer register
// - second write data byte acked and dropped
// - read uses repeated start and read address
// - read sends register selected by pointer
// - acked read byte repeats same register value
// - direct addressing also frees the alert
// - freed alert rearms only on new fault
// - pointer zero is the control register
`timescale 1ns/1ns
module msmb_slave #(
	parameter int FAULT_W = 8
) (
	input  wire logic               mclk,
	input  wire logic               reset,
	msmb_if.dev                     bus,
	input  wire logic [1:0]         addr_select_pin_2,
	input  wire logic [1:0]         addr_select_pin_1,
	input  wire logic [1:0]         addr_select_pin_0,
	input  wire logic [FAULT_W-1:0] alert_faults,
	input  wire logic [7:0]         rd_data,
	output logic      [2:0]         rd_ptr,
	output logic                    wr_stb,
	output logic      [2:0]         wr_ptr,
	output logic      [7:0]         wr_data,
	output logic      [7:0]         ctrl_reg
);
	if (FAULT_W < 1) begin : g_bad_fault_w
		$error("FAULT_W must be at least 1");
	end

	typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} msmb_state_t;

	// strap code to low five address bits
	function automatic logic [4:0] addr_of(input logic [1:0] p2, input logic [1:0] p1,
		input logic [1:0] p0);
		logic [1:0] g;
		logic [3:0] s;
		g = (p2 == msmb_pkg::PIN_LOW) ? 2'h0 : (p2 == msmb_pkg::PIN_HIGH) ? 2'h2 : 2'h1;
		unique case ({p1, p0})
			{msmb_pkg::PIN_OPEN, msmb_pkg::PIN_LOW}:  s = 4'h0;
			{msmb_pkg::PIN_HIGH, msmb_pkg::PIN_OPEN}: s = 4'h1;
			{msmb_pkg::PIN_OPEN, msmb_pkg::PIN_OPEN}: s = 4'h2;
			{msmb_pkg::PIN_OPEN, msmb_pkg::PIN_HIGH}: s = 4'h3;
			{msmb_pkg::PIN_LOW, msmb_pkg::PIN_LOW}:   s = 4'h4;
			{msmb_pkg::PIN_HIGH, msmb_pkg::PIN_HIGH}: s = 4'h5;
			{msmb_pkg::PIN_LOW, msmb_pkg::PIN_OPEN}:  s = 4'h6;
			{msmb_pkg::PIN_LOW, msmb_pkg::PIN_HIGH}:  s = 4'h7;
			// high-low and the unused code land on the extra row
			default:                                  s = 4'h8;
		endcase
		addr_of = s[3] ? (5'h18 + {3'h0, g}) : {g, s[2:0]};
	endfunction : addr_of

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling and bus events

	logic [7:0]        sync_out;
	logic              scl_s;
	logic              sda_s;
	logic              scl_p_q;
	logic              sda_p_q;

	msmb_sync #(.WIDTH(8)) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.din   ({bus.scl, bus.sda, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}),
		.dout  (sync_out)
	);

	assign scl_s = sync_out[7];
	assign sda_s = sync_out[6];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// byte engine

	msmb_state_t       state_q;
	logic [3:0]        cnt_q;
	logic [7:0]        sr_q;
	logic [1:0]        idx_q;
	logic              rw_q;
	logic              ara_q;
	logic              mack_q;
	logic              sda_oe_q;
	logic [7:0]        tx_q;
	logic [7:0]        txb_q;
	logic [2:0]        ptr_q;
	logic [7:0]        ctrl_q;
	logic              wr_stb_q;
	logic [2:0]        wr_ptr_q;
	logic [7:0]        wr_data_q;
	logic              alert_q;
	logic [FAULT_W-1:0] served_q;

	wire [6:0] own7     = {msmb_pkg::ADDR_TOP,
		addr_of(sync_out[5:4], sync_out[3:2], sync_out[1:0])};
	wire       hit_own  = sr_q[7:1] == own7;
	wire       hit_mass = (sr_q[7:1] == msmb_pkg::MASS_ADDR) & ~sr_q[0]
		& ctrl_q[msmb_pkg::MWE_BIT];
	wire       hit_ara  = (sr_q[7:1] == msmb_pkg::ARA_ADDR) & sr_q[0] & alert_q;
	wire       accept   = (idx_q != 2'h0) | hit_own | hit_mass | hit_ara;
	wire       byte_end = (state_q == ST_RX) & scl_fall & (cnt_q == 4'h8);
	wire       tx_end   = (state_q == ST_TX) & scl_fall & (cnt_q == 4'h8);
	wire       is_first = idx_q == 2'h0;
	wire       is_data  = idx_q == 2'h2;
	wire [7:0] reg_val  = (ptr_q == msmb_pkg::PTR_CTRL) ? ctrl_q : rd_data;
	wire [7:0] tx_pick  = hit_ara ? {own7, 1'b0} : reg_val;
	wire [1:0] idx_next = (idx_q == 2'h3) ? 2'h3 : idx_q + 2'h1;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q   <= ST_IDLE;
			cnt_q     <= 4'h0;
			sr_q      <= 8'h00;
			idx_q     <= 2'h0;
			rw_q      <= 1'b0;
			ara_q     <= 1'b0;
			mack_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
			tx_q      <= 8'h00;
			txb_q     <= 8'h00;
			ptr_q     <= msmb_pkg::PTR_RESET;
			ctrl_q    <= msmb_pkg::CTRL_RESET;
			wr_stb_q  <= 1'b0;
			wr_ptr_q  <= 3'h0;
			wr_data_q <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (start_c) begin
				// repeated start re-enters address phase from anywhere
				state_q  <= ST_RX;
				cnt_q    <= 4'h0;
				idx_q    <= 2'h0;
				ara_q    <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (stop_c) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
					end
					ST_RX: begin
						if (scl_rise) begin
							sr_q  <= {sr_q[6:0], sda_s};
							cnt_q <= cnt_q + 4'h1;
						end else if (byte_end) begin
							sda_oe_q <= accept;
							state_q  <= accept ? ST_ACK : ST_IDLE;
							if (is_first) begin
								rw_q  <= sr_q[0];
								ara_q <= hit_ara;
								tx_q  <= tx_pick;
								txb_q <= tx_pick;
							end
							if (idx_q == 2'h1) begin
								ptr_q <= sr_q[2:0];
							end
							if (is_data && ptr_q == msmb_pkg::PTR_CTRL) begin
								ctrl_q <= sr_q;
							end else if (is_data) begin
								wr_ptr_q  <= ptr_q;
								wr_data_q <= sr_q;
							end
							// later bytes fall through with an ack only
							wr_stb_q  <= is_data & (ptr_q != msmb_pkg::PTR_CTRL);
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							cnt_q <= 4'h0;
							if (rw_q) begin
								state_q  <= ST_TX;
								sda_oe_q <= ~tx_q[7];
							end else begin
								state_q  <= ST_RX;
								sda_oe_q <= 1'b0;
								idx_q    <= idx_next;
							end
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (tx_end) begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_TXACK;
						end else if (scl_fall) begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe_q <= ~tx_q[6];
						end
					end
					ST_TXACK: begin
						if (scl_rise) begin
							mack_q <= ~sda_s;
						end else if (scl_fall) begin
							cnt_q <= 4'h0;
							if (mack_q) begin
								state_q  <= ST_TX;
								tx_q     <= txb_q;
								sda_oe_q <= ~txb_q[7];
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alert line

	// a freed fault bit stays served until its source drops, so a steady fault
	// cannot re-pull the line
	wire               release_c = (byte_end & is_first & hit_own)
		| (tx_end & ara_q);
	wire [FAULT_W-1:0] served_d  = alert_faults & (served_q | {FAULT_W{release_c}});

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			served_q <= '0;
			alert_q  <= 1'b0;
		end else begin
			served_q <= served_d;
			alert_q  <= |(alert_faults & ~served_d);
		end
	end

	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe   = sda_oe_q;
	assign bus.dev_alert_o  = 1'b0;
	assign bus.dev_alert_oe = alert_q;
	assign rd_ptr           = ptr_q;
	assign wr_stb           = wr_stb_q;
	assign wr_ptr           = wr_ptr_q;
	assign wr_data          = wr_data_q;
	assign ctrl_reg         = ctrl_q;
endmodule : msmb_slave

//--- verilog/msmb_master.sv
// msmb_master: host end; runs byte/word reads, writes and alert-response reads.
// assumes a slave that never stretches scl; scl is made here by a divider.
`timescale 1ns/1ns
module msmb_master #(
	parameter int QUARTER_CYC = msmb_pkg::QUARTER_CYC
) (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	msmb_if.host                      bus,
	input  wire logic                 cmd_valid,
	input  wire msmb_pkg::msmb_kind_t cmd_kind,
	input  wire logic                 cmd_word,
	input  wire logic [6:0]           cmd_addr,
	input  wire logic [7:0]           cmd_reg,
	input  wire logic [15:0]          cmd_wdata,
	output logic                      cmd_ready,
	output logic                      done,
	output logic                      nack_seen,
	output logic      [15:0]          rd_data,
	output logic                      alert_seen
);
	// sampling latency of the synchroniser needs a few cycles per quarter
	if (QUARTER_CYC < 4) begin : g_bad_quarter
		$error("QUARTER_CYC must be at least 4");
	end

	localparam int QW = $clog2(QUARTER_CYC);

	function automatic msmb_pkg::msmb_op_t op_of(input msmb_pkg::msmb_kind_t k,
		input logic w, input logic [2:0] s);
		op_of = msmb_pkg::OP_STOP;
		unique case (k)
			msmb_pkg::KIND_WRITE: begin
				if (s == 3'h0) op_of = msmb_pkg::OP_START;
				else if (s < 3'h4 || (s == 3'h4 && w)) op_of = msmb_pkg::OP_TX;
			end
			msmb_pkg::KIND_READ: begin
				if (s == 3'h0 || s == 3'h3) op_of = msmb_pkg::OP_START;
				else if (s == 3'h5 || (s == 3'h6 && w)) op_of = msmb_pkg::OP_RX;
				else if (s < 3'h5) op_of = msmb_pkg::OP_TX;
			end
			default: begin
				if (s == 3'h0) op_of = msmb_pkg::OP_START;
				else if (s == 3'h1) op_of = msmb_pkg::OP_TX;
				else if (s == 3'h2) op_of = msmb_pkg::OP_RX;
			end
		endcase
	endfunction : op_of

	msmb_pkg::msmb_kind_t kind_q;
	msmb_pkg::msmb_op_t   cur_op;
	logic                 word_q;
	logic [6:0]           addr_q;
	logic [7:0]           reg_q;
	logic [15:0]          wd_q;
	logic [2:0]           step_q;
	logic [3:0]           bit_q;
	logic [1:0]           ph_q;
	logic [QW-1:0]        qcnt_q;
	logic [8:0]           sh_q;
	logic                 scl_oe_q;
	logic                 sda_oe_q;
	logic                 busy_q;
	logic                 done_q;
	logic                 nack_q;
	logic [15:0]          rd_q;
	logic                 alert_q;
	logic [1:0]           sync_out;
	logic [7:0]           nxt_byte;

	msmb_sync #(.WIDTH(2)) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.din   ({bus.sda, bus.alert_n}),
		.dout  (sync_out)
	);

	wire [2:0] step_inc = step_q + 3'h1;
	wire       tick     = qcnt_q == QW'(QUARTER_CYC - 1);
	wire       last_bit = bit_q == 4'h8;
	wire       is_tx    = cur_op == msmb_pkg::OP_TX;
	wire       rx_ack   = (kind_q == msmb_pkg::KIND_READ) & word_q & (step_q == 3'h5);
	wire       drive    = is_tx ? (~last_bit & ~sh_q[8]) : (last_bit & rx_ack);

	assign cur_op = op_of(kind_q, word_q, step_q);

	always_comb begin
		nxt_byte = 8'h00;
		unique case (step_inc)
			3'h1: nxt_byte = (kind_q == msmb_pkg::KIND_ARA) ? {msmb_pkg::ARA_ADDR, 1'b1}
				: {addr_q, 1'b0};
			3'h2: nxt_byte = reg_q;
			3'h3: nxt_byte = wd_q[7:0];
			3'h4: nxt_byte = (kind_q == msmb_pkg::KIND_READ) ? {addr_q, 1'b1} : wd_q[15:8];
			default: nxt_byte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			qcnt_q <= '0;
		end else begin
			qcnt_q <= (!busy_q || tick) ? '0 : qcnt_q + QW'(1);
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			kind_q   <= msmb_pkg::KIND_WRITE;
			word_q   <= 1'b0;
			addr_q   <= 7'h00;
			reg_q    <= 8'h00;
			wd_q     <= 16'h0000;
			step_q   <= 3'h0;
			bit_q    <= 4'h0;
			ph_q     <= 2'h0;
			sh_q     <= 9'h000;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
			nack_q   <= 1'b0;
			rd_q     <= 16'h0000;
			alert_q  <= 1'b0;
		end else begin
			done_q  <= 1'b0;
			alert_q <= ~sync_out[0];
			if (!busy_q) begin
				if (cmd_valid) begin
					kind_q <= cmd_kind;
					word_q <= cmd_word;
					addr_q <= cmd_addr;
					reg_q  <= cmd_reg;
					wd_q   <= cmd_wdata;
					step_q <= 3'h0;
					bit_q  <= 4'h0;
					ph_q   <= 2'h0;
					nack_q <= 1'b0;
					busy_q <= 1'b1;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				unique case (cur_op)
					msmb_pkg::OP_START: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							2'h3: begin
								scl_oe_q <= 1'b1;
								step_q   <= step_inc;
								sh_q     <= {nxt_byte, 1'b1};
							end
						endcase
					end
					msmb_pkg::OP_TX, msmb_pkg::OP_RX: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= drive;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sh_q     <= {sh_q[7:0], sync_out[1]};
							2'h3: begin
								scl_oe_q <= 1'b1;
								bit_q    <= last_bit ? 4'h0 : bit_q + 4'h1;
								if (last_bit) begin
									sh_q   <= {nxt_byte, 1'b1};
									// missing ack from the slave: go straight to stop
									step_q <= (is_tx & sh_q[0]) ? msmb_pkg::STEP_ABORT : step_inc;
									nack_q <= nack_q | (is_tx & sh_q[0]);
									if (!is_tx && step_q == 3'h6) rd_q[15:8] <= sh_q[8:1];
									else if (!is_tx) rd_q[7:0] <= sh_q[8:1];
								end
							end
						endcase
					end
					default: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							2'h3: begin
								busy_q <= 1'b0;
								done_q <= 1'b1;
							end
						endcase
					end
				endcase
			end
		end
	end

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = sda_oe_q;
	assign cmd_ready       = ~busy_q;
	assign done            = done_q;
	assign nack_seen       = nack_q;
	assign rd_data         = rd_q;
	assign alert_seen      = alert_q;
endmodule : msmb_master

//--- sim/msmb_properties.sv
// msmb_properties: timing and ownership checks on the shared bus and alert line.
// assumes the open-drain signals of msmb_if, mclk domain, instantiated beside it in tb.
`timescale 1ns/1ns
module msmb_properties #(
	parameter int QUARTER_CYC = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic dev_alert_oe,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe
);
	logic [15:0] hi_cnt_q;
	logic [15:0] hi_cnt_d;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// saturate so a long idle never wraps into a short count
	assign hi_cnt_d = !scl ? 16'h0 : (hi_cnt_q == 16'hffff ? hi_cnt_q : hi_cnt_q + 16'h1);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			hi_cnt_q <= 16'h0;
		else
			hi_cnt_q <= hi_cnt_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	a_reset_released: assert property ($fell(reset) |-> !dev_sda_oe && !dev_alert_oe
		&& !host_scl_oe && !host_sda_oe) else $error("line driven right after reset");
	a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives sda high");
	a_host_open_drain: assert property (!(host_scl_oe && host_scl_o)
		&& !(host_sda_oe && host_sda_o)) else $error("host drives a line high");
	a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed sda while scl high");
	a_stop_frees_bus: assert property ($rose(sda) && scl |=> !dev_sda_oe [*8])
		else $error("device drives sda after stop");
	a_start_by_host: assert property ($fell(sda) && scl && $past(scl)
		|-> host_sda_oe && !dev_sda_oe) else $error("start not made by host");
	a_alert_free_low: assert property ($fell(dev_alert_oe) |-> !scl)
		else $error("alert released outside a transfer slot");
	a_scl_high_len: assert property ($fell(scl) |-> hi_cnt_q >= 16'(2 * QUARTER_CYC - 1))
		else $error("scl high phase too short");

	c_ack_slot: cover property (dev_sda_oe && scl);
	c_alert_set: cover property ($rose(dev_alert_oe));
	c_alert_free: cover property ($fell(dev_alert_oe));
	c_start: cover property ($fell(sda) && scl);
endmodule : msmb_properties

//--- sim/tb.sv
// tb: host command port, device straps, fault inputs and register reads driven here.
// assumes both ends joined by msmb_if; host scl divider shortened to keep the run brief.
`timescale 1ns/1ns
module tb;
	localparam int QC = 4;
	logic                 mclk;
	logic                 reset;
	logic [1:0]           pin2;
	logic [1:0]           pin1;
	logic [1:0]           pin0;
	logic [7:0]           faults;
	logic [7:0]           dev_rd;
	logic [2:0]           rd_ptr;
	logic                 wr_stb;
	logic [2:0]           wr_ptr;
	logic [7:0]           wr_data;
	logic [7:0]           ctrl_reg;
	logic                 cmd_valid;
	msmb_pkg::msmb_kind_t cmd_kind;
	logic                 cmd_word;
	logic [6:0]           cmd_addr;
	logic [7:0]           cmd_reg;
	logic [15:0]          cmd_wdata;
	logic                 cmd_ready;
	logic                 done;
	logic                 nack_seen;
	logic [15:0]          rd_word;
	logic                 alert_seen;
	int                   mismatches;
	int                   compares;
	int                   stb_cnt;

	// register file stand-in: value tells which pointer was read
	assign dev_rd = {5'h15, rd_ptr};

	msmb_if u_msmb_if();
	msmb_slave u_msmb_slave(.mclk(mclk), .reset(reset), .bus(u_msmb_if), .addr_select_pin_2(pin2),
		.addr_select_pin_1(pin1), .addr_select_pin_0(pin0), .alert_faults(faults),
		.rd_data(dev_rd), .rd_ptr(rd_ptr), .wr_stb(wr_stb), .wr_ptr(wr_ptr),
		.wr_data(wr_data), .ctrl_reg(ctrl_reg));
	msmb_master #(.QUARTER_CYC(QC)) u_msmb_master(.mclk(mclk), .reset(reset), .bus(u_msmb_if),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_word(cmd_word), .cmd_addr(cmd_addr),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
		.nack_seen(nack_seen), .rd_data(rd_word), .alert_seen(alert_seen));
	msmb_properties #(.QUARTER_CYC(QC)) u_msmb_properties(.mclk(mclk), .reset(reset),
		.scl(u_msmb_if.scl), .sda(u_msmb_if.sda), .dev_sda_o(u_msmb_if.dev_sda_o),
		.dev_sda_oe(u_msmb_if.dev_sda_oe), .dev_alert_oe(u_msmb_if.dev_alert_oe),
		.host_scl_o(u_msmb_if.host_scl_o), .host_scl_oe(u_msmb_if.host_scl_oe),
		.host_sda_o(u_msmb_if.host_sda_o), .host_sda_oe(u_msmb_if.host_sda_oe));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (wr_stb === 1'b1)
			stb_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask : idle

	task automatic run_cmd(input msmb_pkg::msmb_kind_t k, input logic w, input logic [6:0] a,
		input logic [7:0] r, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 100) begin
			mismatches++;
			final_report();
		end
		stb_cnt = 0;
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_word = w;
		cmd_addr = a;
		cmd_reg = r;
		cmd_wdata = d;
		@(negedge mclk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) begin
			mismatches++;
			final_report();
		end
	endtask : run_cmd

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_mass();
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h53, 8'hf8, 16'h0000);
		check(ctrl_reg, 8'h00);
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h5f, 8'h01, 16'h0011);
		check({nack_seen, 8'(stb_cnt)}, {1'b1, 8'h00});
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h53, 8'h00, 16'h0010);
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h5f, 8'h02, 16'h0077);
		check({nack_seen, wr_ptr, wr_data}, {1'b0, 3'h2, 8'h77});
		check(stb_cnt, 1);
	endtask : t_mass

	task automatic t_rw();
		run_cmd(msmb_pkg::KIND_WRITE, 1'b1, 7'h53, 8'hab, 16'h5a3c);
		check({nack_seen, wr_ptr, wr_data}, {1'b0, 3'h3, 8'h3c});
		check({rd_ptr, 8'(stb_cnt)}, {3'h3, 8'h01});
		run_cmd(msmb_pkg::KIND_READ, 1'b0, 7'h53, 8'hfd, 16'h0000);
		check({nack_seen, rd_word[7:0], rd_ptr}, {1'b0, 8'had, 3'h5});
		run_cmd(msmb_pkg::KIND_READ, 1'b1, 7'h53, 8'h18, 16'h0000);
		check(rd_word, 16'h1010);
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h54, 8'h01, 16'h0099);
		check({nack_seen, 8'(stb_cnt)}, {1'b1, 8'h00});
		run_cmd(msmb_pkg::KIND_ARA, 1'b0, 7'h0c, 8'h00, 16'h0000);
		check(nack_seen, 1'b1);
	endtask : t_rw

	task automatic t_alert();
		faults = 8'h01;
		idle(8);
		check(alert_seen, 1'b1);
		run_cmd(msmb_pkg::KIND_ARA, 1'b0, 7'h0c, 8'h00, 16'h0000);
		check({nack_seen, rd_word[7:0]}, {1'b0, 8'ha6});
		idle(40);
		check(alert_seen, 1'b0);
		faults = 8'h03;
		idle(8);
		check(alert_seen, 1'b1);
		run_cmd(msmb_pkg::KIND_WRITE, 1'b0, 7'h53, 8'h01, 16'h0001);
		idle(6);
		check(alert_seen, 1'b0);
		faults = 8'h02;
		idle(4);
		faults = 8'h03;
		idle(8);
		check(alert_seen, 1'b1);
		run_cmd(msmb_pkg::KIND_READ, 1'b0, 7'h53, 8'h01, 16'h0000);
		idle(6);
		check(alert_seen, 1'b0);
		faults = 8'h00;
	endtask : t_alert

	task automatic t_straps();
		logic [12:0] tbl [4] = '{{2'h0, 2'h2, 2'h0, 7'h40}, {2'h2, 2'h2, 2'h2, 7'h4a},
			{2'h1, 2'h1, 2'h0, 7'h5a}, {2'h0, 2'h1, 2'h0, 7'h58}};
		for (int i = 0; i < 4; i++) begin
			{pin2, pin1, pin0} = tbl[i][12:7];
			idle(4);
			run_cmd(msmb_pkg::KIND_WRITE, 1'b0, tbl[i][6:0], 8'h01, 16'h0021);
			check(nack_seen, 1'b0);
			run_cmd(msmb_pkg::KIND_WRITE, 1'b0, tbl[i][6:0] ^ 7'h40, 8'h01, 16'h0021);
			check(nack_seen, 1'b1);
		end
		{pin2, pin1, pin0} = {msmb_pkg::PIN_HIGH, msmb_pkg::PIN_OPEN, msmb_pkg::PIN_HIGH};
		idle(4);
	endtask : t_straps

	initial begin
		reset = 1'b1;
		{pin2, pin1, pin0} = {msmb_pkg::PIN_HIGH, msmb_pkg::PIN_OPEN, msmb_pkg::PIN_HIGH};
		faults = 8'h00;
		cmd_valid = 1'b0;
		cmd_kind = msmb_pkg::KIND_WRITE;
		cmd_word = 1'b0;
		cmd_addr = 7'h00;
		cmd_reg = 8'h00;
		cmd_wdata = 16'h0000;
		mismatches = 0;
		compares = 0;
		stb_cnt = 0;
		idle(2);
		reset = 1'b0;
		idle(4);
		check({ctrl_reg, rd_ptr}, {8'h10, 3'h0});
		t_mass();
		t_rw();
		t_alert();
		t_straps();
		final_report();
	end
endmodule : tb
